// ==== rtl/pbmux_top.v ====
// Port B pin function mux, input routing, port registers and wake-up
//
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "pbmux_defines.vh"
module pbmux_top (
    // APB
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Pins, synchronous to pclk
    input wire [7:0] porta_in,
    input wire [5:0] portb_in,
    output reg [7:0] porta_out,
    output reg [7:0] porta_oe,
    output reg [5:0] portb_out,
    output reg [5:0] portb_oe,
    // Peripheral outputs to place on port B pins 5 and 4
    input wire uart_txd,
    input wire uart_tx_dir,
    input wire serial_clk_out,
    input wire serial_clk_dir,
    input wire serial_cs_out,
    input wire serial_cs_dir,
    // Routed peripheral inputs
    output reg serial_data_in,
    output reg serial_chip_select,
    output reg compact_timer_clock_in,
    output reg periodic_timer_capture_in,
    output reg periodic_timer_clock_in,
    output reg ext_irq_in,
    // Power and interrupt
    input wire sleep_mode,
    output reg wake_req,
    output reg irq
);
    reg [7:0] pblo_reg, pbhi_reg, serial_input_source_select_reg, timer_irq_input_source_select_reg;
    reg [7:0] padata_reg, padir_reg, wakeen_reg, rstcfg_reg;
    reg [5:0] pbdata_reg, pbdir_reg;
    reg [7:0] pa_prev_reg;
    reg [1:0] stat_reg, mask_reg;
    wire wr = psel & penable & pwrite;
    wire [7:0] wd = pwdata[7:0];
    wire [1:0] pb5_f = pbhi_reg[`PBMUX_PB5_LSB +: 2];
    wire [1:0] pb4_f = pbhi_reg[`PBMUX_PB4_LSB +: 2];
    wire [7:0] pa_fall = pa_prev_reg & ~porta_in & wakeen_reg;
    wire wake_evt = sleep_mode & (|pa_fall);
    wire [1:0] ev = {|pa_fall, wake_evt};
    wire [1:0] stat_next = (stat_reg & ~(wr && paddr == `PBMUX_OFF_STAT ?
        wd[1:0] : 2'b00)) | ev; // Set wins over clear
    reg [31:0] rd;
    reg hit;

    // Read mux; port data reads return the data register, so a software
    // bit set/clear read-modify-write keeps the other bits intact
    always @* begin
        rd = 32'h0000_0000;
        hit = 1'b1;
        case (paddr)
            `PBMUX_OFF_PBLO: rd[7:0] = pblo_reg;
            `PBMUX_OFF_PBHI: rd[7:0] = pbhi_reg & `PBMUX_PBHI_MASK;
            `PBMUX_OFF_SERIAL_INPUT_SOURCE_SELECT: rd[7:0] = serial_input_source_select_reg;
            `PBMUX_OFF_TIMER_IRQ_INPUT_SOURCE_SELECT: rd[7:0] = timer_irq_input_source_select_reg & `PBMUX_TIMER_IRQ_INPUT_SOURCE_SELECT_MASK;
            `PBMUX_OFF_PADATA: rd[7:0] = padata_reg;
            `PBMUX_OFF_PADIR: rd[7:0] = padir_reg;
            `PBMUX_OFF_PBDATA: rd[5:0] = pbdata_reg;
            `PBMUX_OFF_PBDIR: rd[5:0] = pbdir_reg;
            `PBMUX_OFF_WAKEEN: rd[7:0] = wakeen_reg;
            `PBMUX_OFF_RSTCFG: rd[7:0] = rstcfg_reg;
            `PBMUX_OFF_PIN: rd[13:0] = {portb_in, porta_in};
            `PBMUX_OFF_SLEEP: rd[0] = sleep_mode;
            `PBMUX_OFF_STAT: rd[1:0] = stat_reg;
            `PBMUX_OFF_MASK: rd[1:0] = mask_reg;
            default: hit = 1'b0;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pblo_reg <= `PBMUX_SEL_RST;
            pbhi_reg <= `PBMUX_SEL_RST;
            serial_input_source_select_reg <= `PBMUX_SEL_RST;
            timer_irq_input_source_select_reg <= `PBMUX_SEL_RST;
            padata_reg <= `PBMUX_PORT_RST;
            padir_reg <= `PBMUX_PORT_RST;
            pbdata_reg <= 6'h3F;
            pbdir_reg <= 6'h3F;
            wakeen_reg <= `PBMUX_SEL_RST;
            rstcfg_reg <= `PBMUX_SEL_RST;
            pa_prev_reg <= `PBMUX_PORT_RST;
            stat_reg <= 2'b00;
            mask_reg <= 2'b00;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pa_prev_reg <= porta_in;
            stat_reg <= stat_next;
            // One wait state: pready rises in the second access cycle
            pready <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~hit;
            prdata <= (psel & penable & ~pready & ~pwrite) ? rd : 32'h0;
            if (wr && !pready) begin
                case (paddr)
                    `PBMUX_OFF_PBLO: pblo_reg <= wd;
                    `PBMUX_OFF_PBHI: pbhi_reg <= wd & `PBMUX_PBHI_MASK;
                    `PBMUX_OFF_SERIAL_INPUT_SOURCE_SELECT: serial_input_source_select_reg <= wd;
                    `PBMUX_OFF_TIMER_IRQ_INPUT_SOURCE_SELECT: timer_irq_input_source_select_reg <= wd & `PBMUX_TIMER_IRQ_INPUT_SOURCE_SELECT_MASK;
                    `PBMUX_OFF_PADATA: padata_reg <= wd;
                    `PBMUX_OFF_PADIR: padir_reg <= wd;
                    `PBMUX_OFF_PBDATA: pbdata_reg <= wd[5:0];
                    `PBMUX_OFF_PBDIR: pbdir_reg <= wd[5:0];
                    `PBMUX_OFF_WAKEEN: wakeen_reg <= wd;
                    `PBMUX_OFF_RSTCFG: rstcfg_reg <= wd;
                    `PBMUX_OFF_MASK: mask_reg <= wd[1:0];
                    default: ;
                endcase
            end
        end
    end

    // Pin drive and input routing, all registered
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            porta_out <= 8'hFF;
            porta_oe <= 8'h00;
            portb_out <= 6'h3F;
            portb_oe <= 6'h00;
            serial_data_in <= 1'b1;
            serial_chip_select <= 1'b1;
            compact_timer_clock_in <= 1'b1;
            periodic_timer_capture_in <= 1'b1;
            periodic_timer_clock_in <= 1'b1;
            ext_irq_in <= 1'b1;
            wake_req <= 1'b0;
            irq <= 1'b0;
        end else begin
            // Data resets high so a fresh output drives high
            porta_out <= padata_reg;
            porta_oe <= ~padir_reg;
            // PA2 drive needs the reset config to release it
            porta_oe[`PBMUX_PA2_BIT] <= ~padir_reg[`PBMUX_PA2_BIT] &
                rstcfg_reg[0];
            portb_out[3:0] <= pbdata_reg[3:0];
            portb_oe[3:0] <= ~pbdir_reg[3:0];
            case (pb5_f)
                2'b01: begin
                    portb_out[5] <= uart_txd;
                    portb_oe[5] <= uart_tx_dir;
                end
                2'b10: begin
                    portb_out[5] <= serial_cs_out;
                    portb_oe[5] <= serial_cs_dir;
                end
                default: begin
                    portb_out[5] <= pbdata_reg[5];
                    portb_oe[5] <= ~pbdir_reg[5];
                end
            endcase
            if (pb4_f == 2'b01) begin
                portb_out[4] <= serial_clk_out;
                portb_oe[4] <= serial_clk_dir;
            end else begin
                portb_out[4] <= pbdata_reg[4];
                portb_oe[4] <= ~pbdir_reg[4];
            end
            // Each input follows only its selected pin
            case (serial_input_source_select_reg[`PBMUX_SDI_LSB +: 2])
                2'b01: serial_data_in <= portb_in[0];
                2'b10: serial_data_in <= portb_in[1];
                default: serial_data_in <= porta_in[5];
            endcase
            case (serial_input_source_select_reg[`PBMUX_CS_LSB +: 2])
                2'b01: serial_chip_select <= porta_in[3];
                2'b10: serial_chip_select <= portb_in[5];
                default: serial_chip_select <= porta_in[6];
            endcase
            case (timer_irq_input_source_select_reg[`PBMUX_COMPACT_TIMER_CLOCK_IN_LSB +: 2])
                2'b01: compact_timer_clock_in <= portb_in[1];
                2'b10: compact_timer_clock_in <= porta_in[4];
                default: compact_timer_clock_in <= porta_in[5];
            endcase
            periodic_timer_capture_in <= timer_irq_input_source_select_reg[`PBMUX_PERIODIC_TIMER_CAPTURE_IN_BIT] ?
                portb_in[0] : porta_in[6];
            periodic_timer_clock_in <= timer_irq_input_source_select_reg[`PBMUX_PERIODIC_TIMER_CLOCK_IN_BIT] ?
                portb_in[4] : porta_in[7];
            ext_irq_in <= timer_irq_input_source_select_reg[`PBMUX_INT_BIT] ?
                portb_in[5] : porta_in[0];
            wake_req <= wake_evt;
            irq <= |(stat_next & mask_reg);
        end
    end
endmodule
`default_nettype wire

// ==== rtl/pbmux_defines.vh ====
// Register map, field positions and reset values for the port B pin mux
//
// Behaviour
// - PB5 field: 00/11 gpio+irq, 01 uart, 10 cs
// - PB4 field: 01 serial clock, else gpio+timer clock
// - High function bits 7:4 read zero
// - Chip select source: PA6, PA3, PB5, PA6
// - Compact clock source: PA5, PB1, PA4, PA5
// - Capture source: PA6 clear, PB0 set
// - Periodic clock source: PA7 clear, PB4 set
// - Interrupt source: PA0 clear, PB5 set
// - Data and direction registers reset all ones
// - New output drives high unless data written
// - Bit set/clear is read-modify-write of byte
// - Falling enabled port A pin wakes device
// - Wake enable is per port A pin
// - PA2 output enable follows reset config
// - Direction bit 0 output, 1 input
`ifndef PBMUX_DEFINES_VH
`define PBMUX_DEFINES_VH

`define PBMUX_OFF_PBLO 12'h000
`define PBMUX_OFF_PBHI 12'h004
`define PBMUX_OFF_SERIAL_INPUT_SOURCE_SELECT 12'h008
`define PBMUX_OFF_TIMER_IRQ_INPUT_SOURCE_SELECT 12'h00C
`define PBMUX_OFF_PADATA 12'h010
`define PBMUX_OFF_PADIR 12'h014
`define PBMUX_OFF_PBDATA 12'h018
`define PBMUX_OFF_PBDIR 12'h01C
`define PBMUX_OFF_WAKEEN 12'h020
`define PBMUX_OFF_RSTCFG 12'h024
`define PBMUX_OFF_PIN 12'h028
`define PBMUX_OFF_SLEEP 12'h02C
`define PBMUX_OFF_STAT 12'h030
`define PBMUX_OFF_MASK 12'h034

`define PBMUX_SEL_RST 8'h00
`define PBMUX_PORT_RST 8'hFF
`define PBMUX_PBHI_MASK 8'h0F
`define PBMUX_TIMER_IRQ_INPUT_SOURCE_SELECT_MASK 8'h1F

`define PBMUX_PB5_LSB 2
`define PBMUX_PB4_LSB 0
`define PBMUX_SDI_LSB 6
`define PBMUX_CS_LSB 2
`define PBMUX_COMPACT_TIMER_CLOCK_IN_LSB 3
`define PBMUX_PERIODIC_TIMER_CAPTURE_IN_BIT 2
`define PBMUX_PERIODIC_TIMER_CLOCK_IN_BIT 1
`define PBMUX_INT_BIT 0
`define PBMUX_PA2_BIT 2

`define PBMUX_ST_WAKE 0
`define PBMUX_ST_EDGE 1

`endif

// ==== test/pbmux_asserts.sv ====
// Port-level checks for the port B pin mux
`timescale 1ns/1ps
`default_nettype none
module pbmux_asserts (
    // Bus
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    // Pins and routed inputs
    input wire logic [7:0] porta_in,
    input wire logic [5:0] portb_in,
    input wire logic periodic_timer_capture_in,
    input wire logic periodic_timer_clock_in,
    input wire logic ext_irq_in,
    input wire logic sleep_mode,
    input wire logic wake_req
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_rdy; psel && penable && !pready |=> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("late ready");
    property p_one; pready |=> !pready; endproperty
    a_one: assert property (p_one) else $error("long ready");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("stray error");
    property p_rdat; !pready |-> prdata == 32'h0000_0000; endproperty
    a_rdat: assert property (p_rdat) else $error("stray data");
    // Both candidate pins agree, so the output is known whatever the select
    property p_irq; $past(presetn) && $past(porta_in[0]) == $past(portb_in[5])
        |-> ext_irq_in == $past(porta_in[0]); endproperty
    a_irq: assert property (p_irq) else $error("irq route");
    property p_cap; $past(presetn) && $past(porta_in[6]) == $past(portb_in[0])
        |-> periodic_timer_capture_in == $past(porta_in[6]); endproperty
    a_cap: assert property (p_cap) else $error("capture route");
    property p_periodic_timer_clock_in; $past(presetn) && $past(porta_in[7]) == $past(portb_in[4])
        |-> periodic_timer_clock_in == $past(porta_in[7]); endproperty
    a_periodic_timer_clock_in: assert property (p_periodic_timer_clock_in) else $error("clock route");
    property p_wake; wake_req |-> $past(sleep_mode)
        && |($past(porta_in, 2) & ~$past(porta_in)); endproperty
    a_wake: assert property (p_wake) else $error("stray wake");
endmodule
bind pbmux_top pbmux_asserts pbmux_asserts_i (.*);
`default_nettype wire

// ==== test/tb.sv ====
// Self-checking bench for the port B pin mux
`timescale 1ns/1ps
`default_nettype none
`include "pbmux_defines.vh"
module tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic sleep = 0, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [7:0] porta_in = 8'hFF, i0, i1;
    logic [5:0] portb_in = 6'h3F, ex;
    // Uart drives 1, clock and chip select drive 0, all enabled
    logic [5:0] per = 6'h35;
    wire [31:0] prdata;
    wire [7:0] porta_out, porta_oe;
    wire [5:0] portb_out, portb_oe, rt;
    wire pready, pslverr, wake_req, irq;
    integer n_mismatch = 0, samples_checked = 0, n_wake = 0, s, k, t;
    pbmux_top pbmux_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .porta_in(porta_in), .portb_in(portb_in), .porta_out(porta_out),
        .porta_oe(porta_oe), .portb_out(portb_out), .portb_oe(portb_oe),
        .uart_txd(per[5]), .uart_tx_dir(per[4]), .serial_clk_out(per[3]),
        .serial_clk_dir(per[2]), .serial_cs_out(per[1]),
        .serial_cs_dir(per[0]), .serial_data_in(rt[5]),
        .serial_chip_select(rt[4]), .compact_timer_clock_in(rt[3]),
        .periodic_timer_capture_in(rt[2]), .periodic_timer_clock_in(rt[1]),
        .ext_irq_in(rt[0]), .sleep_mode(sleep), .wake_req(wake_req),
        .irq(irq));
    always #5 pclk = ~pclk;
    always @(posedge pclk) if (wake_req === 1'b1) n_wake <= n_wake + 1;
    function automatic [5:0] route(input [7:0] a, f, input [13:0] p);
        route[5] = a[7:6] == 2'd1 ? p[8] : a[7:6] == 2'd2 ? p[9] : p[5];
        route[4] = a[3:2] == 2'd1 ? p[3] : a[3:2] == 2'd2 ? p[13] : p[6];
        route[3] = f[4:3] == 2'd1 ? p[9] : f[4:3] == 2'd2 ? p[4] : p[5];
        route[2] = f[2] ? p[8] : p[6];
        route[1] = f[1] ? p[12] : p[7];
        route[0] = f[0] ? p[13] : p[0];
    endfunction
    task chk(input string nm, input [31:0] e, g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    // For reads d is the expected value
    task bus(input [11:0] a, input w, input [31:0] d);
        t = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && t < 20) begin
            @(posedge pclk);
            t++;
        end
        if (t >= 20) n_mismatch++;
        if (!w) chk("prdata", d, prdata);
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task results;
        if (n_mismatch == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #300000;
        n_mismatch++;
        results;
    end
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("oe", 8'h00, porta_oe);
        bus(`PBMUX_OFF_PBLO, 1'b0, 0);
        bus(`PBMUX_OFF_SERIAL_INPUT_SOURCE_SELECT, 1'b0, 0);
        bus(`PBMUX_OFF_TIMER_IRQ_INPUT_SOURCE_SELECT, 1'b0, 0);
        bus(`PBMUX_OFF_PADATA, 1'b0, 8'hFF);
        bus(`PBMUX_OFF_PADIR, 1'b0, 8'hFF);
        bus(`PBMUX_OFF_PBHI, 1'b1, 8'hFF);
        bus(`PBMUX_OFF_PBHI, 1'b0, 8'h0F);
        bus(`PBMUX_OFF_PBLO, 1'b1, 8'hA5);
        bus(`PBMUX_OFF_PBLO, 1'b0, 8'hA5);
        bus(`PBMUX_OFF_PBLO, 1'b1, 8'hA7);
        bus(`PBMUX_OFF_PBLO, 1'b0, 8'hA7);
        bus(12'h038, 1'b0, 0);
        chk("pslverr", 1, err);
        for (s = 0; s < 4; s++) begin
            bus(`PBMUX_OFF_PBHI, 1'b1, {s[1:0], s[1:0]});
            ex = {s == 1 || s == 2, s == 1, s == 1, 1'b0};
            chk("pb54", ex, {portb_oe[5:4], portb_out[5:4] & portb_oe[5:4]});
        end
        bus(`PBMUX_OFF_RSTCFG, 1'b1, 0);
        bus(`PBMUX_OFF_PADIR, 1'b1, 8'hF0);
        chk("oe", 8'h0B, porta_oe);
        chk("out", 8'hFF, porta_out);
        bus(`PBMUX_OFF_RSTCFG, 1'b1, 1);
        chk("oe", 8'h0F, porta_oe);
        bus(`PBMUX_OFF_PADIR, 1'b1, 8'hFF);
        bus(`PBMUX_OFF_PBDATA, 1'b1, 8'h15);
        bus(`PBMUX_OFF_PBDIR, 1'b1, 0);
        chk("pb_oe", 6'h3F, portb_oe);
        chk("pb_out", 6'h15, portb_out);
        bus(`PBMUX_OFF_PBDATA, 1'b0, 8'h15);
        bus(`PBMUX_OFF_PIN, 1'b0, 14'h3FFF);
        bus(`PBMUX_OFF_SLEEP, 1'b0, 0);
        bus(`PBMUX_OFF_PBDIR, 1'b1, 8'h3F);
        for (s = 0; s < 48; s++) begin
            i1 = s < 32 ? s[7:0] : 8'h00;
            i0 = s < 32 ? 8'h00 : {s[3:2], 2'b00, s[1:0], 2'b00};
            bus(`PBMUX_OFF_SERIAL_INPUT_SOURCE_SELECT, 1'b1, i0);
            bus(`PBMUX_OFF_TIMER_IRQ_INPUT_SOURCE_SELECT, 1'b1, i1);
            for (k = 0; k < 14; k++) begin
                {portb_in, porta_in} <= 14'h0001 << k;
                repeat (2) @(posedge pclk);
                ex = route(i0, i1, 14'h0001 << k);
                chk("route", ex, rt);
            end
        end
        porta_in <= 8'hFF;
        bus(`PBMUX_OFF_MASK, 1'b1, 1);
        bus(`PBMUX_OFF_WAKEEN, 1'b1, 8'h08);
        sleep <= 1'b1;
        porta_in <= 8'hFB;
        repeat (3) @(posedge pclk);
        chk("irq", 0, irq);
        porta_in <= 8'hF3;
        repeat (3) @(posedge pclk);
        chk("irq", 1, irq);
        chk("wake", 1, n_wake);
        bus(`PBMUX_OFF_STAT, 1'b0, 3);
        bus(`PBMUX_OFF_MASK, 1'b1, 0);
        chk("irq", 0, irq);
        bus(`PBMUX_OFF_MASK, 1'b1, 1);
        chk("irq", 1, irq);
        bus(`PBMUX_OFF_STAT, 1'b1, 3);
        chk("irq", 0, irq);
        bus(`PBMUX_OFF_STAT, 1'b0, 0);
        results;
    end
endmodule
`default_nettype wire
